/* design/serial_port.v */
// Notes on behaviour
// - Multiprocessor enable bit turns address recognition on and off.
// - With recognition on, only matching address frames set the receive flag.
// - Mode 1 with recognition: stop bit is ninth bit; flag needs match and stop.
// - Multiprocessor enable has no effect in mode 0.
// - Given address compares own address only where mask bits are one.
// - Broadcast address is own address OR mask; its zero bits are don't care.
// - Address frame accepted on given or broadcast match.
// - Own address and mask reset to zero so every address matches.
// - Receive and transmit flags OR into one request; only software clears them.
// - Request reaches core only with serial and global enables set.
// - Receive flag set at the stop bit sample in modes 1 to 3 in either detection setting; mode 0 never receives.
// - Bit 7 is framing error flag with detection on, else mode bit 0.
// - Bit 4 enables reception.
// - Modes 2 and 3 send bit 3 as ninth data bit.
// - Bit 2 captures stop bit in mode 1, ninth bit in modes 2 and 3.
// - Transmit flag set after last data bit is sent.
// - Data buffer read gives last received byte; write starts transmission.
// - Baud control bit 4 runs the internal generator.
// - Baud control bits 3 and 2 pick internal or timer 1 for tx and rx.
// - Baud control bit 1 selects high or low generator speed.
// - Baud control bit 0 lets mode 0 use the internal generator.
// - Reload register value loads the generator counter each period.
// - Modes 2 and 3 frame: start, eight data LSB first, ninth, stop.
// - Framing error flag stays set until software or reset clears it.
// - Mode 2 rate is clock/32, or clock/16 with baud doubling.
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_map.vh"
module serial_port (
  input wire clk,
  input wire resetn,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire sfr_rd,
  output reg [7:0] sfr_rdata,
  input wire framing_detect_select,
  input wire baud_double,
  input wire serial_irq_enable,
  input wire global_irq_enable,
  input wire timer1_tick,
  input wire rxd_in,
  output reg txd_out,
  output reg serial_irq
);
  localparam ST_IDLE = 4'b0001;
  localparam ST_START = 4'b0010;
  localparam ST_BITS = 4'b0100;
  localparam ST_STOP = 4'b1000;

  reg [7:0] serial_control_reg;
  reg [7:0] baud_generator_control_reg;
  reg [7:0] baud_reload_value_reg;
  reg [7:0] slave_own_address_reg;
  reg [7:0] slave_address_mask_reg;
  reg framing_error_flag_reg;
  reg [7:0] rx_byte_reg;
  reg rxd_meta_reg;
  reg rxd_sync_reg;

  function addr_match;
    input [7:0] rx;
    input [7:0] own;
    input [7:0] mask;
    reg [7:0] bcast;
    begin
      bcast = own | mask;
      addr_match = (((rx ^ own) & mask) == 8'h00)
        | (((rx ^ bcast) & bcast) == 8'h00);
    end
  endfunction

  wire [1:0] port_mode;
  wire multiproc_enable;
  wire rx_enable;
  wire tx_ninth_bit;
  wire gen_tick;
  assign port_mode = {serial_control_reg[`SERIAL_CONTROL_FE_SM0], serial_control_reg[`SERIAL_CONTROL_SM1]};
  assign multiproc_enable = serial_control_reg[`SERIAL_CONTROL_SM2] & (port_mode != 2'd0);
  assign rx_enable = serial_control_reg[`SERIAL_CONTROL_REN];
  assign tx_ninth_bit = serial_control_reg[`SERIAL_CONTROL_TB8];

  baud_tick_gen u_gen (
    .clk(clk),
    .resetn(resetn),
    .run(baud_generator_control_reg[`BDR_RUN]),
    .speed_high(baud_generator_control_reg[`BDR_SPD]),
    .reload(baud_reload_value_reg),
    .tick(gen_tick)
  );

  // Fixed-rate dividers for mode 0 and mode 2, one-cycle enables
  reg fix_div_reg;
  reg [3:0] m0_div_reg;
  wire fix_tick;
  wire m0_fixed_tick;
  // Sixteen oversample ticks per bit give clk/32, or clk/16 when doubled
  assign fix_tick = baud_double | !fix_div_reg;
  assign m0_fixed_tick = (m0_div_reg == 4'd0);

  // Bit-rate enables: 16x oversampled in async modes
  reg tx_src;
  reg rx_src;
  always @* begin
    case (port_mode)
      2'd0: begin
        tx_src = baud_generator_control_reg[`BDR_MODE0_BAUD_SOURCE] ? gen_tick : m0_fixed_tick;
        rx_src = tx_src;
      end
      2'd2: begin
        tx_src = fix_tick;
        rx_src = fix_tick;
      end
      default: begin
        tx_src = baud_generator_control_reg[`BDR_TX_BAUD_SOURCE] ? gen_tick : timer1_tick;
        rx_src = baud_generator_control_reg[`BDR_RX_BAUD_SOURCE] ? gen_tick : timer1_tick;
      end
    endcase
  end

  // Transmitter: start, 8 data LSB first, optional ninth, stop
  reg [3:0] tx_state_reg;
  reg [3:0] tx_os_reg;
  reg [3:0] tx_bit_reg;
  reg [8:0] tx_shift_reg;
  reg tx_start_reg;
  reg tx_done_set;
  wire tx_bit_tick;
  wire nine_bit;
  assign nine_bit = port_mode[1];
  assign tx_bit_tick = tx_src & ((port_mode == 2'd0) | (tx_os_reg == 4'hf));

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      tx_state_reg <= ST_IDLE;
      tx_os_reg <= 4'h0;
      tx_bit_reg <= 4'h0;
      tx_shift_reg <= 9'h1ff;
      txd_out <= 1'b1;
      tx_done_set <= 1'b0;
    end else begin
      tx_done_set <= 1'b0;
      if (tx_src) begin
        tx_os_reg <= tx_os_reg + 4'h1;
      end
      case (tx_state_reg)
        ST_IDLE: begin
          txd_out <= 1'b1;
          if (tx_start_reg) begin
            tx_shift_reg <= {tx_ninth_bit, rx_byte_reg};
            tx_os_reg <= 4'h0;
            tx_state_reg <= ST_START;
          end
        end
        ST_START: begin
          txd_out <= 1'b0;
          if (tx_bit_tick) begin
            tx_bit_reg <= 4'h0;
            tx_state_reg <= ST_BITS;
          end
        end
        ST_BITS: begin
          txd_out <= tx_shift_reg[0];
          if (tx_bit_tick) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[8:1]};
            tx_bit_reg <= tx_bit_reg + 4'h1;
            if (tx_bit_reg == (nine_bit ? 4'd8 : 4'd7)) begin
              tx_done_set <= 1'b1;
              tx_state_reg <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          txd_out <= 1'b1;
          if (tx_bit_tick) begin
            tx_state_reg <= ST_IDLE;
          end
        end
        default: tx_state_reg <= ST_IDLE;
      endcase
    end
  end

  // Receiver
  reg [3:0] rx_state_reg;
  reg [3:0] rx_os_reg;
  reg [3:0] rx_bit_reg;
  reg [8:0] rx_shift_reg;
  reg rx_done_set;
  reg rx_bit8_load;
  reg rx_bit8_val;
  reg fe_set;
  reg rxd_prev_reg;
  reg rx_push;
  reg [7:0] rx_push_data;
  wire rx_sample;
  wire rx_ninth;
  wire frame_ok;
  wire buf_in_ready;
  wire buf_out_valid;
  wire [7:0] buf_out_data;
  assign rx_sample = rx_src & (rx_os_reg == 4'h7);
  assign rx_ninth = nine_bit ? rx_shift_reg[8] : rxd_sync_reg;

  // Flag decision at end of frame; stop bit replaces ninth bit in mode 1
  assign frame_ok = !multiproc_enable
    | (rx_ninth & addr_match(nine_bit ? rx_shift_reg[7:0] : rx_shift_reg[8:1],
        slave_own_address_reg, slave_address_mask_reg)
       & (nine_bit | rxd_sync_reg));

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rx_state_reg <= ST_IDLE;
      rx_os_reg <= 4'h0;
      rx_bit_reg <= 4'h0;
      rx_shift_reg <= 9'h000;
      rx_done_set <= 1'b0;
      rx_bit8_load <= 1'b0;
      rx_bit8_val <= 1'b0;
      fe_set <= 1'b0;
      rxd_prev_reg <= 1'b1;
      rx_push <= 1'b0;
      rx_push_data <= 8'h00;
    end else begin
      rx_done_set <= 1'b0;
      rx_bit8_load <= 1'b0;
      fe_set <= 1'b0;
      rxd_prev_reg <= rxd_sync_reg;
      if (rx_push & buf_in_ready) begin
        rx_push <= 1'b0;
      end
      if (rx_src) begin
        rx_os_reg <= rx_os_reg + 4'h1;
      end
      case (rx_state_reg)
        ST_IDLE: begin
          if (rx_enable & rxd_prev_reg & !rxd_sync_reg & (port_mode != 2'd0)) begin
            rx_os_reg <= 4'h0;
            rx_state_reg <= ST_START;
          end
        end
        ST_START: begin
          if (rx_sample) begin
            rx_bit_reg <= 4'h0;
            rx_state_reg <= rxd_sync_reg ? ST_IDLE : ST_BITS;
          end
        end
        ST_BITS: begin
          if (rx_sample) begin
            rx_shift_reg <= {rxd_sync_reg, rx_shift_reg[8:1]};
            rx_bit_reg <= rx_bit_reg + 4'h1;
            if (rx_bit_reg == (nine_bit ? 4'd8 : 4'd7)) begin
              rx_state_reg <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          if (rx_sample) begin
            rx_state_reg <= ST_IDLE;
            if (framing_detect_select & !rxd_sync_reg) begin
              fe_set <= 1'b1;
            end
            if (frame_ok) begin
              // Flag raised during stop bit, after ninth bit is known
              rx_done_set <= 1'b1;
              rx_bit8_load <= 1'b1;
              rx_bit8_val <= rx_ninth;
              rx_push <= 1'b1;
              rx_push_data <= nine_bit ? rx_shift_reg[7:0] : rx_shift_reg[8:1];
            end
          end
        end
        default: rx_state_reg <= ST_IDLE;
      endcase
    end
  end

  // Holding buffer; register side drains it every cycle a byte is held
  rx_skid_buffer u_buf (
    .clk(clk),
    .resetn(resetn),
    .in_valid(rx_push),
    .in_ready(buf_in_ready),
    .in_data(rx_push_data),
    .out_valid(buf_out_valid),
    .out_ready(1'b1),
    .out_data(buf_out_data)
  );

  // Register file and synchroniser
  wire wr_serial_data_buffer;
  assign wr_serial_data_buffer = sfr_wr & (sfr_addr == `SFR_SERIAL_DATA_BUFFER);
  reg [7:0] rx_data_reg;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
      serial_control_reg <= `RESET_SERIAL_CONTROL;
      baud_generator_control_reg <= `RESET_BAUD_CONTROL;
      baud_reload_value_reg <= 8'h00;
      slave_own_address_reg <= `RESET_SLAVE_ADDR;
      slave_address_mask_reg <= `RESET_SLAVE_MASK;
      framing_error_flag_reg <= 1'b0;
      rx_byte_reg <= 8'h00;
      rx_data_reg <= 8'h00;
      tx_start_reg <= 1'b0;
      fix_div_reg <= 1'b0;
      m0_div_reg <= 4'd0;
      sfr_rdata <= 8'h00;
      serial_irq <= 1'b0;
    end else begin
      rxd_meta_reg <= rxd_in;
      rxd_sync_reg <= rxd_meta_reg;
      fix_div_reg <= ~fix_div_reg;
      m0_div_reg <= (m0_div_reg == 4'd`MODE0_DIV - 4'd1) ? 4'd0 : m0_div_reg + 4'd1;
      tx_start_reg <= wr_serial_data_buffer;
      if (wr_serial_data_buffer) begin
        rx_byte_reg <= sfr_wdata;
      end
      if (buf_out_valid) begin
        rx_data_reg <= buf_out_data;
      end
      if (sfr_wr) begin
        case (sfr_addr)
          `SFR_SERIAL_CONTROL: begin
            if (framing_detect_select) begin
              serial_control_reg <= {serial_control_reg[7], sfr_wdata[6:0]};
              framing_error_flag_reg <= sfr_wdata[7];
            end else begin
              serial_control_reg <= sfr_wdata;
            end
          end
          `SFR_BAUD_GENERATOR_CONTROL: baud_generator_control_reg <= sfr_wdata & `BDR_WRITE_MASK;
          `SFR_BAUD_RELOAD_VALUE: baud_reload_value_reg <= sfr_wdata;
          `SFR_SLAVE_OWN_ADDRESS: slave_own_address_reg <= sfr_wdata;
          `SFR_SLAVE_ADDRESS_MASK: slave_address_mask_reg <= sfr_wdata;
          default: ;
        endcase
      end
      // Hardware sets win over a software clear in the same cycle
      if (fe_set) begin
        framing_error_flag_reg <= 1'b1;
      end
      if (rx_done_set) begin
        serial_control_reg[`SERIAL_CONTROL_RI] <= 1'b1;
      end
      if (tx_done_set) begin
        serial_control_reg[`SERIAL_CONTROL_TI] <= 1'b1;
      end
      if (rx_bit8_load) begin
        serial_control_reg[`SERIAL_CONTROL_RB8] <= rx_bit8_val;
      end
      serial_irq <= (serial_control_reg[`SERIAL_CONTROL_RI] | serial_control_reg[`SERIAL_CONTROL_TI])
        & serial_irq_enable & global_irq_enable;
      case (sfr_addr)
        `SFR_SERIAL_CONTROL: sfr_rdata <= framing_detect_select ?
          {framing_error_flag_reg, serial_control_reg[6:0]} : serial_control_reg;
        `SFR_SERIAL_DATA_BUFFER: sfr_rdata <= rx_data_reg;
        `SFR_BAUD_GENERATOR_CONTROL: sfr_rdata <= baud_generator_control_reg;
        `SFR_BAUD_RELOAD_VALUE: sfr_rdata <= baud_reload_value_reg;
        `SFR_SLAVE_OWN_ADDRESS: sfr_rdata <= slave_own_address_reg;
        `SFR_SLAVE_ADDRESS_MASK: sfr_rdata <= slave_address_mask_reg;
        default: sfr_rdata <= 8'h00;
      endcase
    end
  end
endmodule // serial_port
`default_nettype wire

/* inc/serial_port_map.vh */
`ifndef SERIAL_PORT_MAP_VH
`define SERIAL_PORT_MAP_VH
`define SFR_BAUD_RELOAD_VALUE 8'h91
`define SFR_BAUD_GENERATOR_CONTROL 8'h92
`define SFR_SERIAL_CONTROL 8'h98
`define SFR_SERIAL_DATA_BUFFER 8'h99
`define SFR_SLAVE_OWN_ADDRESS 8'ha9
`define SFR_SLAVE_ADDRESS_MASK 8'hb9
`define SERIAL_CONTROL_FE_SM0 7
`define SERIAL_CONTROL_SM1 6
`define SERIAL_CONTROL_SM2 5
`define SERIAL_CONTROL_REN 4
`define SERIAL_CONTROL_TB8 3
`define SERIAL_CONTROL_RB8 2
`define SERIAL_CONTROL_TI 1
`define SERIAL_CONTROL_RI 0
`define BDR_RUN 4
`define BDR_TX_BAUD_SOURCE 3
`define BDR_RX_BAUD_SOURCE 2
`define BDR_SPD 1
`define BDR_MODE0_BAUD_SOURCE 0
`define BDR_WRITE_MASK 8'h1f
`define RESET_SERIAL_CONTROL 8'h00
`define RESET_BAUD_CONTROL 8'h00
`define RESET_SLAVE_ADDR 8'h00
`define RESET_SLAVE_MASK 8'h00
`define LOW_SPEED_PRESCALE 6
`define MODE2_DIV_SLOW 32
`define MODE2_DIV_FAST 16
`define MODE0_DIV 12
`define OVERSAMPLE 16
`endif

/* design/baud_tick_gen.v */
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_map.vh"
// Reloadable 8-bit baud counter; each overflow is one tick
module baud_tick_gen (
  input wire clk,
  input wire resetn,
  input wire run,
  input wire speed_high,
  input wire [7:0] reload,
  output reg tick
);
  reg [7:0] count_reg;
  reg [2:0] pre_reg;
  wire step;
  assign step = run & (speed_high | (pre_reg == 3'd0));
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_reg <= 8'h00;
      pre_reg <= 3'd0;
      tick <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (!run) begin
        pre_reg <= 3'd0;
        count_reg <= reload;
      end else begin
        // Low speed divides by a fixed prescale
        pre_reg <= (pre_reg == 3'd`LOW_SPEED_PRESCALE - 3'd1) ? 3'd0 : pre_reg + 3'd1;
        if (step) begin
          if (count_reg == 8'hff) begin
            count_reg <= reload;
            tick <= 1'b1;
          end else begin
            count_reg <= count_reg + 8'h01;
          end
        end
      end
    end
  end
endmodule // baud_tick_gen
`default_nettype wire

/* design/rx_skid_buffer.v */
`timescale 1ns/1ps
`default_nettype none
// Two-entry buffer between the receiver and the data register
module rx_skid_buffer (
  input wire clk,
  input wire resetn,
  input wire in_valid,
  output wire in_ready,
  input wire [7:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [7:0] out_data
);
  reg [7:0] mem [0:1];
  reg wr_ptr_reg;
  reg rd_ptr_reg;
  reg [1:0] count_reg;
  wire push;
  wire pop;
  assign in_ready = (count_reg != 2'd2);
  assign out_valid = (count_reg != 2'd0);
  assign out_data = mem[rd_ptr_reg];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  always @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      count_reg <= count_reg + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // rx_skid_buffer
`default_nettype wire

/* test/serial_port_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_port_chk (
  input wire clk,
  input wire resetn,
  input wire [7:0] sfr_addr,
  input wire [7:0] sfr_wdata,
  input wire sfr_wr,
  input wire [7:0] sfr_rdata,
  input wire serial_irq_enable,
  input wire global_irq_enable,
  input wire serial_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  wire mapped = sfr_addr == 8'h91 || sfr_addr == 8'h92 || sfr_addr == 8'h98 ||
                sfr_addr == 8'h99 || sfr_addr == 8'ha9 || sfr_addr == 8'hb9;
  sequence wr_then_hold(a);
    sfr_wr && sfr_addr == a ##1 sfr_addr == a && !sfr_wr;
  endsequence
  sequence quiet_ctrl;
    (sfr_addr == 8'h98 && !sfr_wr) [*3];
  endsequence
  property shows_write(a, m);
    wr_then_hold(a) |=> sfr_rdata == ($past(sfr_wdata, 2) & m);
  endproperty
  chk_own_write: assert property (shows_write(8'ha9, 8'hff))
    else $error("own address readback wrong");
  chk_mask_write: assert property (shows_write(8'hb9, 8'hff))
    else $error("address mask readback wrong");
  chk_reload_write: assert property (shows_write(8'h91, 8'hff))
    else $error("reload readback wrong");
  chk_bdr_write: assert property (shows_write(8'h92, 8'h1f))
    else $error("baud control readback wrong");
  chk_bdr_reserved: assert property ($past(sfr_addr) == 8'h92 |-> sfr_rdata[7:5] == 3'h0)
    else $error("baud control upper bits not zero");
  chk_unmapped_zero: assert property (!$past(mapped) |-> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  // Flags and error bit never drop while the control address is held without a write
  chk_flags_sticky: assert property (quiet_ctrl |=> ((~sfr_rdata & $past(sfr_rdata)) & 8'h83) == 8'h00)
    else $error("flag cleared without write");
  chk_irq_gate: assert property (serial_irq |-> $past(serial_irq_enable && global_irq_enable))
    else $error("request without enables");
  chk_irq_off: assert property (!(serial_irq_enable && global_irq_enable) |=> !serial_irq)
    else $error("request not masked");
endmodule // serial_port_chk
`default_nettype wire

/* test/serial_master.sv */
`timescale 1ns/1ps
`default_nettype none
module serial_master #(parameter integer BIT = 32) (
  input wire clk,
  output logic line_out,
  input wire line_in
);
  logic [8:0] got;
  integer n_got;
  integer k;
  initial begin
    line_out = 1'b1;
    n_got = 0;
    got = 9'h000;
  end
  task automatic wait_cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Start, eight data LSB first, ninth, stop; bad stop leaves line low
  task automatic send(input logic [7:0] d, input logic b9, input logic stop_ok);
    logic [10:0] f;
    integer i;
    f = {stop_ok, b9, d, 1'b0};
    for (i = 0; i < 11; i++) begin
      @(posedge clk);
      #1 line_out = f[i];
      wait_cyc(BIT - 1);
    end
    @(posedge clk);
    #1 line_out = 1'b1;
    wait_cyc(BIT);
  endtask
  always begin
    @(negedge line_in);
    wait_cyc(BIT / 2);
    for (k = 0; k < 9; k++) begin
      wait_cyc(BIT);
      got[k] = line_in;
    end
    n_got = n_got + 1;
    wait_cyc(BIT);
  end
endmodule // serial_master
`default_nettype wire

/* test/tb_serial_port.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_serial_port;
  logic clk, resetn, sfr_wr, sfr_rd, fds, bdbl, sie, gie, t1, rxd;
  logic [7:0] sfr_addr, sfr_wdata, v;
  wire [7:0] sfr_rdata;
  wire txd, irq;
  integer n_fail, check_count, i, n;
  // {expected flag, ninth bit, address}
  logic [9:0] tab [0:5] = '{10'h33c, 10'h3f0, 10'h1f2, 10'h3fb, 10'h3ff, 10'h055};
  logic [7:0] regs [0:3] = '{8'h92, 8'h98, 8'ha9, 8'hb9};
  serial_port i_serial_port (
    .clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .framing_detect_select(fds),
    .baud_double(bdbl), .serial_irq_enable(sie), .global_irq_enable(gie),
    .timer1_tick(t1), .rxd_in(rxd), .txd_out(txd), .serial_irq(irq));
  // Timer 1 tick every other cycle gives a 32-cycle bit
  serial_master #(.BIT(32)) i_serial_master (.clk(clk), .line_out(rxd), .line_in(txd));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) #1 t1 = ~t1;
  task chk(input string name, input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(posedge clk);
    #1 sfr_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge clk);
    #1 sfr_addr = a;
    repeat (2) @(posedge clk);
    #1 v = sfr_rdata;
  endtask
  task frame(input logic [7:0] d, input logic b9, input logic stop_ok);
    i_serial_master.send(d, b9, stop_ok);
    repeat (8) @(posedge clk);
    rd(8'h98);
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    #60000;
    n_fail++;
    end_of_test;
  end
  initial begin
    {resetn, sfr_wr, sfr_rd, fds, bdbl, t1} = 6'h00;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sie = 1'b1;
    gie = 1'b1;
    n_fail = 0;
    check_count = 0;
    repeat (2) @(posedge clk);
    #1 resetn = 1'b1;
    for (i = 0; i < 4; i++) begin
      rd(regs[i]);
      chk("reset value", v, 8'h00);
    end
    rd(8'h55);
    chk("unmapped", v, 8'h00);
    wr(8'h92, 8'hff);
    rd(8'h92);
    chk("baud control", v, 8'h1f);
    wr(8'h92, 8'h00);
    wr(8'h91, 8'hc3);
    rd(8'h91);
    chk("reload", v, 8'hc3);
    $display("test registers done");
    wr(8'h98, 8'hf0);
    for (i = 0; i < 6; i++) begin
      if (i == 1) begin
        wr(8'ha9, 8'hf1);
        wr(8'hb9, 8'hfa);
      end
      frame(tab[i][7:0], tab[i][8], 1'b1);
      chk("rx flag", v[0], tab[i][9]);
      chk("irq", irq, tab[i][9]);
      if (tab[i][9]) begin
        chk("ninth", v[2], 1'b1);
        rd(8'h99);
        chk("rx data", v, tab[i][7:0]);
      end
      if (i == 4) begin
        @(posedge clk);
        #1 gie = 1'b0;
        repeat (2) @(posedge clk);
        #1 chk("irq masked", irq, 1'b0);
        gie = 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("irq unmasked", irq, 1'b1);
      end
      wr(8'h98, 8'hf0);
    end
    $display("test address done");
    n = i_serial_master.n_got;
    wr(8'h98, 8'hd8);
    wr(8'h99, 8'ha5);
    for (i = 0; i < 2000 && i_serial_master.n_got == n; i++) @(posedge clk);
    chk("tx frame", i_serial_master.got, 9'h1a5);
    repeat (40) @(posedge clk);
    rd(8'h98);
    chk("tx flag", v[1], 1'b1);
    chk("tx irq", irq, 1'b1);
    wr(8'h98, 8'hd0);
    // Move off the control address so the detection switch shows no false drop
    rd(8'h99);
    $display("test transmit done");
    @(posedge clk);
    #1 fds = 1'b1;
    wr(8'h98, 8'h50);
    frame(8'h3c, 1'b0, 1'b0);
    chk("frame error", v[7], 1'b1);
    frame(8'h3d, 1'b0, 1'b1);
    chk("frame error kept", v[7], 1'b1);
    wr(8'h98, 8'h40);
    rd(8'h98);
    chk("frame error clear", v[7], 1'b0);
    frame(8'h66, 1'b1, 1'b1);
    chk("rx disabled", v[0], 1'b0);
    $display("test framing done");
    @(posedge clk);
    #1 fds = 1'b0;
    wr(8'h98, 8'h90);
    frame(8'h5a, 1'b0, 1'b1);
    chk("mode 2 flag", v[0], 1'b1);
    rd(8'h99);
    chk("mode 2 data", v, 8'h5a);
    wr(8'h91, 8'hfe);
    wr(8'h92, 8'h1e);
    wr(8'h98, 8'h70);
    // Mode 1: the stop bit sits in the ninth-bit slot of the sent frame
    frame(8'hf0, 1'b0, 1'b1);
    chk("mode 1 bad stop", v[0], 1'b0);
    frame(8'hf0, 1'b1, 1'b1);
    chk("mode 1 match", v[0], 1'b1);
    chk("mode 1 stop bit", v[2], 1'b1);
    $display("test modes done");
    end_of_test;
  end
endmodule // tb_serial_port
bind serial_port serial_port_chk i_serial_port_chk (
  .clk(clk), .resetn(resetn), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
  .sfr_rdata(sfr_rdata), .serial_irq_enable(serial_irq_enable),
  .global_irq_enable(global_irq_enable), .serial_irq(serial_irq));
`default_nettype wire
